/* hdl/timer_event_counter_16bit.sv */
// Sixteen-bit timer/event counter with an APB register slave.
//
// Operation
// - 16-bit up counter, pin edges or clock/4.
// - Low-byte write only fills low buffer.
// - High-byte write loads preload with buffer.
// - High-byte read returns count, captures low.
// - Low-byte read returns the low buffer.
// - Mode field bits 7:6 select mode.
// - Control bit 3 picks rising or falling.
// - Control bit 4 enables counting.
// - Control bits 2:0 and 5 read zero.
// - Count to FFFFH, then reload preload.
// - Overflow sets request flag with reload.
// - Pulse mode counts one level, clears enable.
// - Pulse mode keeps result until re-enabled.
// - Pulse mode starts on an edge only.
// - Pulse mode overflow reloads and requests.
// - Hardware clears enable only in pulse mode.
// - Overflow wakes the halted core.
// - Cleared interrupt enable blocks the interrupt.
// - Preload write while stopped loads counter.
// - Preload write while running waits reload.
// - High-byte read blocks the counting clock.
// - Pulse width counts in clock/4 units.
`timescale 1ns/1ps
`include "timer_event_counter_defines.svh"
`default_nettype none

module timer_event_counter_16bit (
  // Clock and reset.
  input  wire logic                            mclk,
  input  wire logic                            rst_n,
  // Register bus.
  input  wire timer_event_counter_pkg::apb_req_t apbReq,
  output var  timer_event_counter_pkg::apb_rsp_t apbRsp,
  // Timer input pin, asynchronous to mclk.
  input  wire logic                            timerInputPin,
  // Requests towards the core.
  output logic                                 overflowIrq,
  output logic                                 wakeRequest
);

  timer_event_counter_pkg::state_t cur;
  timer_event_counter_pkg::state_t next_cur;

  // Decodes one register word address.
  function automatic logic regHit(input logic [7:0] addr,
                                  input logic [7:0] regAddr);
    regHit = (addr == regAddr);
  endfunction : regHit

  // Tells whether an address belongs to the register map.
  function automatic logic mapped(input logic [7:0] addr);
    mapped = regHit(addr, `CNT_HIGH_ADDR) | regHit(addr, `CNT_LOW_ADDR) |
             regHit(addr, `CNT_CTRL_ADDR) | regHit(addr, `IRQ_CTRL_ADDR);
  endfunction : mapped

  // Bus phases: take is the first access cycle, done the completing one.
  logic take;
  logic done;
  logic doneWrite;
  logic takeRead;
  logic highReadTake;
  logic ctrlWrite;
  logic preloadWrite;
  assign take = apbReq.psel & apbReq.penable & ~cur.rsp.pready;
  assign done = apbReq.psel & apbReq.penable & cur.rsp.pready;
  assign doneWrite = done & apbReq.pwrite & mapped(apbReq.paddr);
  assign takeRead = take & ~apbReq.pwrite;
  assign highReadTake = takeRead & regHit(apbReq.paddr, `CNT_HIGH_ADDR);
  assign ctrlWrite = doneWrite & regHit(apbReq.paddr, `CNT_CTRL_ADDR);
  assign preloadWrite = doneWrite & regHit(apbReq.paddr, `CNT_HIGH_ADDR);

  // Edge detection works on the second synchroniser stage only.
  logic riseSeen;
  logic fallSeen;
  logic activeEdge;
  logic returnEdge;
  logic divTick;
  assign riseSeen = cur.pinSync & ~cur.pinPrev;
  assign fallSeen = ~cur.pinSync & cur.pinPrev;
  assign activeEdge = cur.edgeFall ? fallSeen : riseSeen;
  assign returnEdge = cur.edgeFall ? riseSeen : fallSeen;
  assign divTick = (cur.prescale == `PRESCALE_LAST);

  // Count tick per mode; a high-byte read holds it off for consistency.
  logic tick;
  always_comb begin
    tick = 1'b0;
    if (cur.countOn && !highReadTake) begin
      unique case (cur.mode)
        timer_event_counter_pkg::MODE_EVENT: tick = activeEdge;
        timer_event_counter_pkg::MODE_TIMER: tick = divTick;
        timer_event_counter_pkg::MODE_PULSE: begin
          tick = divTick &&
                 (cur.pwState == timer_event_counter_pkg::PW_COUNT) &&
                 !returnEdge;
        end
        timer_event_counter_pkg::MODE_OFF:   tick = 1'b0;
      endcase
    end
  end

  logic overflow;
  assign overflow = tick && (cur.count == `COUNT_MAX);

  // Next-state logic for the whole block.
  always_comb begin
    next_cur = cur;
    // Two-stage pin synchroniser, then the edge history flop.
    next_cur.pinMeta = timerInputPin;
    next_cur.pinSync = cur.pinMeta;
    next_cur.pinPrev = cur.pinSync;
    // The divider runs freely so clock/4 phases are not tied to enables.
    next_cur.prescale = cur.prescale + 2'h1;
    next_cur.wake = 1'b0;

    // Counting, with reload on overflow.
    if (overflow) begin
      next_cur.count = cur.preload;
      next_cur.flag = 1'b1;
      next_cur.wake = 1'b1;
    end else if (tick) begin
      next_cur.count = cur.count + 16'h0001;
    end

    // Pulse-width sequencer.
    if (cur.mode != timer_event_counter_pkg::MODE_PULSE || !cur.countOn) begin
      if (cur.pwState != timer_event_counter_pkg::PW_DONE || cur.countOn) begin
        next_cur.pwState = timer_event_counter_pkg::PW_IDLE;
      end
    end else begin
      unique case (cur.pwState)
        timer_event_counter_pkg::PW_IDLE,
        timer_event_counter_pkg::PW_DONE: begin
          // A fresh enable arms the sequencer; a level alone starts nothing.
          next_cur.pwState = timer_event_counter_pkg::PW_WAIT;
        end
        timer_event_counter_pkg::PW_WAIT: begin
          if (activeEdge) begin
            next_cur.pwState = timer_event_counter_pkg::PW_COUNT;
          end
        end
        timer_event_counter_pkg::PW_COUNT: begin
          if (returnEdge) begin
            next_cur.pwState = timer_event_counter_pkg::PW_DONE;
            next_cur.countOn = 1'b0;
          end
        end
      endcase
    end

    // Bus response: one wait cycle, then pready for exactly one cycle.
    next_cur.rsp.pready = take;
    next_cur.rsp.pslverr = take & ~mapped(apbReq.paddr);
    if (take) begin
      next_cur.rsp.prdata = 32'h0000_0000;
    end
    if (takeRead) begin
      if (regHit(apbReq.paddr, `CNT_HIGH_ADDR)) begin
        next_cur.rsp.prdata[7:0] = cur.count[15:8];
        next_cur.lowBuf = cur.count[7:0];
      end else if (regHit(apbReq.paddr, `CNT_LOW_ADDR)) begin
        next_cur.rsp.prdata[7:0] = cur.lowBuf;
      end else if (regHit(apbReq.paddr, `CNT_CTRL_ADDR)) begin
        // Unused control bits keep the zero loaded into prdata at take.
        next_cur.rsp.prdata[7:6] = cur.mode;
        next_cur.rsp.prdata[`CTRL_ON_BIT] = cur.countOn;
        next_cur.rsp.prdata[`CTRL_EDGE_BIT] = cur.edgeFall;
      end else if (regHit(apbReq.paddr, `IRQ_CTRL_ADDR)) begin
        next_cur.rsp.prdata[`IRQ_FLAG_BIT] = cur.flag;
        next_cur.rsp.prdata[`IRQ_EN_BIT] = cur.irqEnable;
      end
    end

    // Register writes take effect on the completing edge.
    if (doneWrite) begin
      if (regHit(apbReq.paddr, `CNT_LOW_ADDR)) begin
        next_cur.lowBuf = apbReq.pwdata[7:0];
      end
      if (preloadWrite) begin
        next_cur.preload = {apbReq.pwdata[7:0], cur.lowBuf};
        if (!cur.countOn) begin
          next_cur.count = {apbReq.pwdata[7:0], cur.lowBuf};
        end
      end
      if (ctrlWrite) begin
        // A software write wins over the automatic enable clear.
        next_cur.mode = timer_event_counter_pkg::mode_t'(
          apbReq.pwdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB]);
        next_cur.countOn = apbReq.pwdata[`CTRL_ON_BIT];
        next_cur.edgeFall = apbReq.pwdata[`CTRL_EDGE_BIT];
      end
      if (regHit(apbReq.paddr, `IRQ_CTRL_ADDR)) begin
        next_cur.irqEnable = apbReq.pwdata[`IRQ_EN_BIT];
        // Set beats clear, so an overflow in this cycle is not lost.
        next_cur.flag = apbReq.pwdata[`IRQ_FLAG_BIT] | overflow;
      end
    end

    next_cur.irq = next_cur.flag & next_cur.irqEnable;
  end

  // State register; reset values are constants only.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur.pinMeta   <= 1'b0;
      cur.pinSync   <= 1'b0;
      cur.pinPrev   <= 1'b0;
      cur.prescale  <= 2'h0;
      cur.count     <= `COUNT_RESET;
      cur.preload   <= `COUNT_RESET;
      cur.lowBuf    <= `BYTE_RESET;
      cur.mode      <= timer_event_counter_pkg::MODE_OFF;
      cur.edgeFall  <= 1'b0;
      cur.countOn   <= 1'b0;
      cur.flag      <= 1'b0;
      cur.irqEnable <= 1'b0;
      cur.pwState   <= timer_event_counter_pkg::PW_IDLE;
      cur.rsp       <= '0;
      cur.irq       <= 1'b0;
      cur.wake      <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register.
  assign apbRsp = cur.rsp;
  assign overflowIrq = cur.irq;
  assign wakeRequest = cur.wake;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence sOverflow;
    tick && (cur.count == `COUNT_MAX);
  endsequence

  sequence sHighRead;
    highReadTake && !preloadWrite;
  endsequence

  // Pulse sequencer armed and waiting for its starting edge.
  sequence sPwWaiting;
    (cur.pwState == timer_event_counter_pkg::PW_WAIT) && cur.countOn &&
    (cur.mode == timer_event_counter_pkg::MODE_PULSE);
  endsequence

  AST_OVF_RELOAD: assert property (
    sOverflow |=> (cur.count == $past(cur.preload)))
    else $error("Counter did not reload on overflow.");

  AST_OVF_FLAG_WAKE: assert property (
    sOverflow |=> cur.flag && cur.wake ##1 !cur.wake)
    else $error("Overflow did not raise flag and one wake pulse.");

  AST_LOW_WRITE: assert property (
    doneWrite && regHit(apbReq.paddr, `CNT_LOW_ADDR) |=>
      (cur.preload == $past(cur.preload)) &&
      (cur.lowBuf == $past(apbReq.pwdata[7:0])))
    else $error("Low-byte write disturbed preload or missed buffer.");

  AST_HIGH_WRITE: assert property (
    preloadWrite |=>
      cur.preload == {$past(apbReq.pwdata[7:0]), $past(cur.lowBuf)})
    else $error("High-byte write did not form preload.");

  AST_HIGH_READ: assert property (
    sHighRead |=> (cur.rsp.prdata[7:0] == $past(cur.count[15:8])) &&
                  (cur.lowBuf == $past(cur.count[7:0])) && cur.rsp.pready)
    else $error("High-byte read wrong data or no capture.");

  AST_LOW_READ: assert property (
    takeRead && regHit(apbReq.paddr, `CNT_LOW_ADDR) |=>
      cur.rsp.prdata[7:0] == $past(cur.lowBuf))
    else $error("Low-byte read did not return buffer.");

  AST_CTRL_ZERO: assert property (
    takeRead && regHit(apbReq.paddr, `CNT_CTRL_ADDR) |=>
      (cur.rsp.prdata[2:0] == 3'h0) && !cur.rsp.prdata[5])
    else $error("Unused control bits read non-zero.");

  AST_READ_BLOCK: assert property (
    sHighRead |=> cur.count == $past(cur.count))
    else $error("Counter moved during high-byte read.");

  AST_PW_DONE: assert property (
    (cur.pwState == timer_event_counter_pkg::PW_COUNT) && cur.countOn &&
    (cur.mode == timer_event_counter_pkg::MODE_PULSE) && returnEdge &&
    !ctrlWrite |=> !cur.countOn ##1 !cur.countOn || $past(ctrlWrite))
    else $error("Pulse measurement did not clear enable.");

  AST_NO_AUTOCLEAR: assert property (
    (cur.mode != timer_event_counter_pkg::MODE_PULSE) && cur.countOn &&
    !ctrlWrite |=> cur.countOn)
    else $error("Enable cleared outside pulse mode.");

  AST_MODE_OFF: assert property (
    (cur.mode == timer_event_counter_pkg::MODE_OFF) && !preloadWrite |=>
      (cur.count == $past(cur.count)) && !cur.wake)
    else $error("Counter moved in unused mode.");

  AST_IRQ_GATE: assert property (
    doneWrite && regHit(apbReq.paddr, `IRQ_CTRL_ADDR) &&
    !apbReq.pwdata[`IRQ_EN_BIT] |=> !cur.irq && !cur.irqEnable)
    else $error("Interrupt raised while disabled.");

  AST_PRELOAD_STOPPED: assert property (
    preloadWrite && !cur.countOn |=> cur.count == cur.preload)
    else $error("Stopped counter not loaded by preload write.");

  AST_PRELOAD_RUNNING: assert property (
    preloadWrite && cur.countOn && !overflow && !tick |=>
      cur.count == $past(cur.count))
    else $error("Running counter loaded by preload write.");

  // A measured width is frozen until software starts a new one.
  AST_PW_HOLD: assert property (
    (cur.pwState == timer_event_counter_pkg::PW_DONE) && !cur.countOn &&
    !preloadWrite |=> cur.count == $past(cur.count))
    else $error("Measured width changed after the measurement.");

  AST_PW_LEVEL: assert property (
    sPwWaiting ##0 !activeEdge |=>
      cur.pwState != timer_event_counter_pkg::PW_COUNT)
    else $error("Pulse count started without an edge.");

  AST_PW_ARM: assert property (
    sPwWaiting ##0 activeEdge |=>
      cur.pwState == timer_event_counter_pkg::PW_COUNT)
    else $error("Pulse count missed its starting edge.");

  // Timer mode advances only on the divided clock phase.
  AST_TIMER_STEP: assert property (
    (cur.mode == timer_event_counter_pkg::MODE_TIMER) && cur.countOn &&
    divTick && !highReadTake && (cur.count != `COUNT_MAX) |=>
      cur.count == $past(cur.count) + 16'h0001)
    else $error("Timer missed a divided clock tick.");

  AST_TIMER_IDLE: assert property (
    (cur.mode == timer_event_counter_pkg::MODE_TIMER) && !divTick &&
    !preloadWrite |=> cur.count == $past(cur.count))
    else $error("Timer moved between divided clock ticks.");

  AST_PULSE_RATE: assert property (
    (cur.mode == timer_event_counter_pkg::MODE_PULSE) && !divTick &&
    !preloadWrite |=> cur.count == $past(cur.count))
    else $error("Pulse width counted off the divided clock.");

  // Event mode follows the selected pin edge and nothing else.
  AST_EVENT_STEP: assert property (
    (cur.mode == timer_event_counter_pkg::MODE_EVENT) && cur.countOn &&
    activeEdge && !highReadTake && (cur.count != `COUNT_MAX) |=>
      cur.count == $past(cur.count) + 16'h0001)
    else $error("Event counter missed an active edge.");

  AST_EVENT_OTHER: assert property (
    (cur.mode == timer_event_counter_pkg::MODE_EVENT) && !activeEdge &&
    !preloadWrite |=> cur.count == $past(cur.count))
    else $error("Event counter moved without an active edge.");

  AST_ON_NEEDED: assert property (
    !cur.countOn && !preloadWrite |=> cur.count == $past(cur.count))
    else $error("Counter moved while counting was off.");

  // The core is only woken by a real overflow.
  AST_WAKE_ONLY: assert property (
    !overflow |=> !cur.wake)
    else $error("Wake request without an overflow.");

endmodule : timer_event_counter_16bit

`default_nettype wire

/* hdl/timer_event_counter_defines.svh */
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TIMER_EVENT_COUNTER_DEFINES_SVH
`define TIMER_EVENT_COUNTER_DEFINES_SVH
`define CNT_HIGH_IDX    8'h0F
`define CNT_LOW_IDX     8'h10
`define CNT_CTRL_IDX    8'h11
`define IRQ_CTRL_IDX    8'h12
`define CNT_HIGH_ADDR   8'h3C
`define CNT_LOW_ADDR    8'h40
`define CNT_CTRL_ADDR   8'h44
`define IRQ_CTRL_ADDR   8'h48
`define CTRL_MODE_LSB   6
`define CTRL_ON_BIT     4
`define CTRL_EDGE_BIT   3
`define IRQ_FLAG_BIT    6
`define IRQ_EN_BIT      2
`define COUNT_RESET     16'h0000
`define BYTE_RESET      8'h00
`define COUNT_MAX       16'hFFFF
`define SYS_DIVIDE      4
`define PRESCALE_LAST   2'h3
`endif

/* hdl/timer_event_counter_pkg.sv */
// Types shared by the timer/event counter and its bench.
`default_nettype none
package timer_event_counter_pkg;
  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_EVENT = 2'b01,
    MODE_TIMER = 2'b10,
    MODE_PULSE = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    PW_IDLE  = 2'b00,
    PW_WAIT  = 2'b01,
    PW_COUNT = 2'b11,
    PW_DONE  = 2'b10
  } pw_state_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic      pinMeta;
    logic      pinSync;
    logic      pinPrev;
    logic [1:0] prescale;
    logic [15:0] count;
    logic [15:0] preload;
    logic [7:0] lowBuf;
    mode_t     mode;
    logic      edgeFall;
    logic      countOn;
    logic      flag;
    logic      irqEnable;
    pw_state_t pwState;
    apb_rsp_t  rsp;
    logic      irq;
    logic      wake;
  } state_t;
endpackage : timer_event_counter_pkg
`default_nettype wire

/* tb/pin_source.sv */
// Model of the pulse and event source that drives the timer pin.
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Pulse request from the bench.
  input  wire logic       go,
  input  wire logic       idleLvl,
  input  wire logic [7:0] len,
  // Timer pin.
  output logic            pin
);
  logic [7:0] left;
  // A pulse lasts len clocks; callers keep len at two or more.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin  <= 1'b0;
      left <= 8'h00;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
      if (left == 8'h01) pin <= idleLvl;
    end else if (go) begin
      pin  <= ~idleLvl;
      left <= len;
    end else begin
      pin <= idleLvl;
    end
  end
endmodule : pin_source
`default_nettype wire

/* tb/timer_event_counter_16bit_test.sv */
// Self-checking bench for the sixteen-bit timer/event counter.
`timescale 1ns/1ps
`include "timer_event_counter_defines.svh"
`default_nettype none
module timer_event_counter_16bit_test;
  logic mclk, rst_n, pin, irq, wake, go, idleLvl, lastErr;
  logic [7:0] len, b;
  logic [15:0] v, v2;
  timer_event_counter_pkg::apb_req_t req;
  timer_event_counter_pkg::apb_rsp_t rsp;
  int n_errors, compares, seed, cyc, k;

  timer_event_counter_16bit dut (.mclk(mclk), .rst_n(rst_n),
    .apbReq(req), .apbRsp(rsp), .timerInputPin(pin),
    .overflowIrq(irq), .wakeRequest(wake));
  pin_source src (.mclk(mclk), .rst_n(rst_n), .go(go),
    .idleLvl(idleLvl), .len(len), .pin(pin));

  // Control bits kept for the compare are the mode and edge fields only; enable is masked out.
  function automatic logic [7:0] ctrlView(input logic [7:0] d);
    return d & 8'hC8;
  endfunction : ctrlView
  // A pulse of w clocks spans about w/4 divided ticks.
  function automatic logic [15:0] expTicks(input int w);
    return 16'(w / 4);
  endfunction : expTicks

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("Summary: %0d compares, %0d errors", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] rd);
    @(posedge mclk);
    req.psel    <= 1'b1;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= {24'h000000, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    // Only pready or the bench timeout ends this wait.
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata[7:0];
    lastErr = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] t;
    apb(1'b1, a, d, t);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    apb(1'b0, a, 8'h00, d);
  endtask : rd
  // High byte first, so the low byte is captured with it.
  task automatic rdCount(output logic [15:0] c);
    rd(`CNT_HIGH_ADDR, c[15:8]);
    rd(`CNT_LOW_ADDR, c[7:0]);
  endtask : rdCount
  task automatic setCount(input logic [15:0] c);
    wr(`CNT_LOW_ADDR, c[7:0]);
    wr(`CNT_HIGH_ADDR, c[15:8]);
  endtask : setCount
  task automatic pulse(input logic [7:0] w);
    @(posedge mclk);
    go  <= 1'b1;
    len <= w;
    @(posedge mclk);
    go  <= 1'b0;
    repeat (int'(w) + 8) @(posedge mclk);
  endtask : pulse

  // Free-running clock at 250 MHz.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // A hang ends the run as a failure.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    rst_n = 1'b0; req = '0; go = 1'b0; idleLvl = 1'b0; len = 8'h02;
    seed = 89; n_errors = 0; compares = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`CNT_CTRL_ADDR, b);
    check("ctrl reset", b, 16'h0000);
    rdCount(v);
    check("count reset", v, 16'h0000);
    rd(8'h50, b);
    check("unmapped err", lastErr, 16'h0001);
    check("unmapped data", b, 16'h0000);
    $display("test reset done");
    // Byte pairing through the low buffer while stopped.
    wr(`CNT_LOW_ADDR, 8'h34);
    rdCount(v);
    check("low only", v, 16'h0000);
    // The high-byte read above overwrote the buffer with the count.
    wr(`CNT_LOW_ADDR, 8'h34);
    wr(`CNT_HIGH_ADDR, 8'h12);
    rdCount(v);
    check("pair load", v, 16'h1234);
    wr(`CNT_LOW_ADDR, 8'h77);
    rd(`CNT_LOW_ADDR, b);
    check("low buffer", b, 16'h0077);
    for (int i = 0; i < 8; i++) begin
      k = $random(seed);
      wr(`CNT_CTRL_ADDR, 8'(k) & 8'hEF);
      rd(`CNT_CTRL_ADDR, b);
      check("ctrl view", b, ctrlView(8'(k) & 8'hEF));
    end
    wr(`CNT_CTRL_ADDR, 8'h00);
    $display("test registers done");
    // Timer mode overflow with a preload changed while running.
    setCount(16'hFFF0);
    wr(`IRQ_CTRL_ADDR, 8'h04);
    wr(`CNT_CTRL_ADDR, 8'h90);
    setCount(16'h1200);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wake !== 1'b1 && k < 300);
    check("wake", wake, 16'h0001);
    repeat (2) @(posedge mclk);
    check("irq", irq, 16'h0001);
    rdCount(v);
    check("reload high", v[15:8], 16'h0012);
    rd(`IRQ_CTRL_ADDR, b);
    check("flag", b, 16'h0044);
    rd(`CNT_CTRL_ADDR, b);
    check("enable kept", b, 16'h0090);
    wr(`IRQ_CTRL_ADDR, 8'h40);
    repeat (2) @(posedge mclk);
    check("irq masked", irq, 16'h0000);
    wr(`CNT_CTRL_ADDR, 8'h80);
    rdCount(v);
    repeat (40) @(posedge mclk);
    rdCount(v2);
    check("stopped", v2, v);
    wr(`IRQ_CTRL_ADDR, 8'h00);
    $display("test timer done");
    // Event counting on both edge choices, then the unused mode.
    for (int e = 0; e < 2; e++) begin
      setCount(16'h0000);
      k = 1 + ($unsigned($random(seed)) % 8);
      wr(`CNT_CTRL_ADDR, (e != 0) ? 8'h58 : 8'h50);
      repeat (k) pulse(8'h04);
      wr(`CNT_CTRL_ADDR, 8'h40);
      rdCount(v);
      check("events", v, 16'(k));
    end
    setCount(16'h0000);
    wr(`CNT_CTRL_ADDR, 8'h10);
    repeat (3) pulse(8'h04);
    rdCount(v);
    check("mode off", v, 16'h0000);
    wr(`CNT_CTRL_ADDR, 8'h00);
    $display("test events done");
    // Pulse width: level alone never starts, one shot, then falling.
    idleLvl <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(`CNT_CTRL_ADDR, 8'hD0);
    repeat (30) @(posedge mclk);
    rdCount(v);
    check("level only", v, 16'h0000);
    idleLvl <= 1'b0;
    repeat (6) @(posedge mclk);
    pulse(8'd40);
    rdCount(v);
    check("width", 16'(v >= expTicks(40) - 1 && v <= expTicks(40) + 1),
          16'h0001);
    rd(`CNT_CTRL_ADDR, b);
    check("auto off", b, 16'h00C0);
    pulse(8'd40);
    rdCount(v2);
    check("one shot", v2, v);
    setCount(16'h0000);
    idleLvl <= 1'b1;
    repeat (6) @(posedge mclk);
    wr(`CNT_CTRL_ADDR, 8'hD8);
    pulse(8'd60);
    rdCount(v);
    check("low width", 16'(v >= expTicks(60) - 1 && v <= expTicks(60) + 1),
          16'h0001);
    $display("test pulse done");
    stop_test();
  end
endmodule : timer_event_counter_16bit_test
`default_nettype wire
